// ### src/ictl_pkg.sv
package ictl_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  // ==========================================================
  localparam logic [15:0] IDX_CTRL1 = 16'h0800;
  localparam logic [15:0] IDX_CTRL2 = 16'h0082;
  localparam logic [15:0] IDX_PEND = 16'h00b0;
  localparam logic [15:0] FLAG_IDX [3] = '{16'h0084, 16'h0086, 16'h0088};
  localparam logic [15:0] EN_IDX [3] = '{16'h008c, 16'h008e, 16'h0600};
  localparam logic [15:0] PRIO_IDX [11] = '{
    16'h0094, 16'h9600, 16'h0098, 16'h009a, 16'h009c, 16'h3600,
    16'h00a0, 16'h00a2, 16'h00a4, 16'h00a6, 16'h00a8};

  // ==========================================================
  // Implemented bits and reset values
  // ==========================================================
  localparam logic [15:0] FLAG_MASK [3] = '{16'hffff, 16'hffff, 16'h067f};
  localparam logic [15:0] PRIO_MASK [11] = '{
    16'h7777, 16'h7777, 16'h7777, 16'h7777, 16'h7777, 16'h7777,
    16'h7777, 16'h7777, 16'h7777, 16'h0777, 16'h0770};
  localparam logic [15:0] PRIO_RST [11] = '{
    16'h4444, 16'h4444, 16'h4444, 16'h4444, 16'h4444, 16'h4444,
    16'h4444, 16'h4444, 16'h4444, 16'h0444, 16'h0440};
  localparam logic [15:0] CTRL1_MASK = 16'h871e;
  localparam logic [15:0] CTRL2_MASK = 16'h801f;
  localparam logic [15:0] CTRL1_RST = 16'h0000;
  localparam logic [15:0] CTRL2_RST = 16'h0000;
  localparam logic [47:0] FLAG_RST = 48'h0;
  localparam int ALT_BIT = 15;
  localparam int TEMP_DISABLE_ACTIVE_BIT = 14;

  // ==========================================================
  // Sources and vectors
  // ==========================================================
  localparam int EXT_N = 5;
  localparam int PRI_SRC_N = 44;
  localparam logic [5:0] EXT_SRC [5] = '{6'h00, 6'h10, 6'h17, 6'h24, 6'h25};
  localparam logic [5:0] VEC_BASE = 6'h08;
  localparam logic [3:0] TEMP_DISABLE_ACTIVE_FLOOR = 4'h6;

  typedef struct packed {
    logic [4:0] flags;
    logic [15:0] w3;
    logic [15:0] w2;
    logic [15:0] w1;
    logic [15:0] w0;
  } ictl_ctx_t;

  typedef struct packed {
    logic req;
    logic [3:0] level;
    logic [5:0] vector;
  } ictl_irq_t;

endpackage : ictl_pkg

// ### src/ictl_top.sv
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module ictl_top #(
  parameter int ADDR_W = 18
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [ADDR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic [4:0] ext_request_inputs_in,
  input wire logic [47:0] periph_req_in,
  input wire logic [3:0] cpu_priority_level_in,
  input wire logic cpu_sleep_in,
  input wire logic temp_disable_active_in,
  input wire logic shadow_push_in,
  input wire logic shadow_pop_in,
  input wire ictl_pkg::ictl_ctx_t core_ctx_in,
  output ictl_pkg::ictl_ctx_t shadow_ctx_out,
  output logic shadow_pop_valid_out,
  output ictl_pkg::ictl_irq_t irq_out,
  output logic wake_out,
  output logic alternate_table_select_out
);

  // ==========================================================
  // Bus decode
  // ==========================================================
  logic [15:0] idx;
  logic [15:0] wmask;
  logic [15:0] wdat;
  logic wr;
  logic [15:0] rdata;
  logic [47:0] flags_q;
  logic [47:0] flags_d;
  logic [47:0] en_q;
  logic [47:0] en_d;
  logic [15:0] prio_q [11];
  logic [15:0] ctrl1_q;
  logic [15:0] ctrl2_q;
  logic [47:0] set_req;
  logic [4:0] ext_edge;

  assign idx = 16'(wb_adr_in >> 2);
  assign wmask = {{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
  assign wdat = wb_dat_in[15:0];
  // Write lands on the edge where the master samples ack high
  assign wr = wb_cyc_in & wb_stb_in & wb_we_in & wb_ack_out;

  // Read mux; no path here reaches the shadow store
  // Shadow not mapped
  always_comb begin
    rdata = 16'h0000;
    for (int w = 0; w < 3; w++) begin
      if (idx == ictl_pkg::FLAG_IDX[w]) begin
        rdata = flags_q[w*16 +: 16];
      end
      if (idx == ictl_pkg::EN_IDX[w]) begin
        rdata = en_q[w*16 +: 16];
      end
    end
    for (int k = 0; k < 11; k++) begin
      if (idx == ictl_pkg::PRIO_IDX[k]) begin
        rdata = prio_q[k];
      end
    end
    if (idx == ictl_pkg::IDX_CTRL1) begin
      rdata = ctrl1_q;
    end
    if (idx == ictl_pkg::IDX_CTRL2) begin
      rdata = ctrl2_q;
      rdata[ictl_pkg::TEMP_DISABLE_ACTIVE_BIT] = temp_disable_active_in;
    end
    if (idx == ictl_pkg::IDX_PEND) begin
      rdata = {4'h0, irq_out.level, 2'b00, irq_out.vector};
    end
  end

  // One-cycle ack; unmapped words answer zero and drop writes
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= wb_cyc_in & wb_stb_in & ~wb_ack_out;
      wb_dat_out <= {16'h0000, rdata};
    end
  end

  // ==========================================================
  // External inputs
  // ==========================================================
  logic [4:0] ext_s1_q;
  logic [4:0] ext_s2_q;
  logic [4:0] ext_prev_q;

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ext_s1_q <= 5'h00;
      ext_s2_q <= 5'h00;
      ext_prev_q <= 5'h00;
    end else begin
      ext_s1_q <= ext_request_inputs_in;
      ext_s2_q <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
    end
  end

  // Polarity bit clear picks rising edge, set picks falling edge
  always_comb begin
    ext_edge = 5'h00;
    set_req = 48'h0;
    for (int e = 0; e < ictl_pkg::EXT_N; e++) begin
      ext_edge[e] = ctrl2_q[e] ? (ext_prev_q[e] & ~ext_s2_q[e])
                               : (~ext_prev_q[e] & ext_s2_q[e]);
      set_req[ictl_pkg::EXT_SRC[e]] = ext_edge[e];
    end
    set_req = set_req | periph_req_in;
  end

  // ==========================================================
  // Flag, enable, priority and control registers
  // ==========================================================
  always_comb begin
    flags_d = flags_q;
    en_d = en_q;
    for (int w = 0; w < 3; w++) begin
      if (wr && idx == ictl_pkg::FLAG_IDX[w]) begin
        flags_d[w*16 +: 16] = (flags_q[w*16 +: 16] &
          ~(wmask & ictl_pkg::FLAG_MASK[w])) |
          (wdat & wmask & ictl_pkg::FLAG_MASK[w]);
      end
      if (wr && idx == ictl_pkg::EN_IDX[w]) begin
        en_d[w*16 +: 16] = (en_q[w*16 +: 16] &
          ~(wmask & ictl_pkg::FLAG_MASK[w])) |
          (wdat & wmask & ictl_pkg::FLAG_MASK[w]);
      end
      flags_d[w*16 +: 16] = flags_d[w*16 +: 16] |
        (set_req[w*16 +: 16] & ictl_pkg::FLAG_MASK[w]);
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flags_q <= ictl_pkg::FLAG_RST;
      en_q <= ictl_pkg::FLAG_RST;
    end else begin
      flags_q <= flags_d;
      en_q <= en_d;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int k = 0; k < 11; k++) begin
        prio_q[k] <= ictl_pkg::PRIO_RST[k];
      end
    end else begin
      for (int k = 0; k < 11; k++) begin
        if (wr && idx == ictl_pkg::PRIO_IDX[k]) begin
          prio_q[k] <= (prio_q[k] & ~(wmask & ictl_pkg::PRIO_MASK[k])) |
            (wdat & wmask & ictl_pkg::PRIO_MASK[k]);
        end
      end
    end
  end

  // Trap status bits are plain storage; traps live elsewhere
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl1_q <= ictl_pkg::CTRL1_RST;
      ctrl2_q <= ictl_pkg::CTRL2_RST;
      alternate_table_select_out <= 1'b0;
    end else begin
      if (wr && idx == ictl_pkg::IDX_CTRL1) begin
        ctrl1_q <= (ctrl1_q & ~(wmask & ictl_pkg::CTRL1_MASK)) |
          (wdat & wmask & ictl_pkg::CTRL1_MASK);
      end
      if (wr && idx == ictl_pkg::IDX_CTRL2) begin
        ctrl2_q <= (ctrl2_q & ~(wmask & ictl_pkg::CTRL2_MASK)) |
          (wdat & wmask & ictl_pkg::CTRL2_MASK);
      end
      alternate_table_select_out <= ctrl2_q[ictl_pkg::ALT_BIT];
    end
  end

  // ==========================================================
  // Arbitration
  // ==========================================================
  logic [3:0] best_lvl;
  logic [5:0] best_src;
  logic [3:0] floor_lvl;
  logic best_ok;

  // Ties go to the lowest source number, which keeps order fixed
  always_comb begin
    logic [3:0] lvl;
    lvl = 4'h0;
    best_lvl = 4'h0;
    best_src = 6'h00;
    for (int i = 0; i < ictl_pkg::PRI_SRC_N; i++) begin
      lvl = {1'b0, prio_q[i/4][(i%4)*4 +: 3]};
      if (flags_q[i] && en_q[i] && lvl > best_lvl) begin
        best_lvl = lvl;
        best_src = 6'(i);
      end
    end
    // Temporary disable still lets level 7 through
    if (temp_disable_active_in && cpu_priority_level_in < 4'h6) begin
      floor_lvl = ictl_pkg::TEMP_DISABLE_ACTIVE_FLOOR;
    end else begin
      floor_lvl = cpu_priority_level_in;
    end
    best_ok = best_lvl > floor_lvl;
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_out <= '0;
    end else begin
      irq_out.req <= best_ok;
      irq_out.level <= best_ok ? best_lvl : 4'h0;
      irq_out.vector <= best_ok ? 6'(best_src + ictl_pkg::VEC_BASE) : 6'h00;
    end
  end

  // Wake in step with the request
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wake_out <= 1'b0;
    end else begin
      wake_out <= best_ok & cpu_sleep_in;
    end
  end

  // ==========================================================
  // Shadow store
  // ==========================================================
  // One level only: a nested push loses the outer context
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      shadow_ctx_out <= '0;
      shadow_pop_valid_out <= 1'b0;
    end else begin
      if (shadow_push_in) begin
        shadow_ctx_out <= core_ctx_in;
      end
      shadow_pop_valid_out <= shadow_pop_in;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  a_push_capture: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    shadow_push_in |=> shadow_ctx_out == $past(core_ctx_in))
    else $error("shadow push did not capture context");

  a_shadow_hold: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    !shadow_push_in |=> $stable(shadow_ctx_out))
    else $error("shadow changed without push");

  a_edge_sets_flag: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    ext_edge[0] |=> flags_q[0])
    else $error("external edge did not set its flag");

  a_level_quiet: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (ext_s2_q[4] == ext_prev_q[4]) && !periph_req_in[37] && !wr &&
    !flags_q[37] |=> !flags_q[37])
    else $error("static level raised a request");

  a_unimpl_zero: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    wb_cyc_in && wb_stb_in && !wb_ack_out &&
    idx == ictl_pkg::FLAG_IDX[2] |=> wb_dat_out[15:11] == 5'h00 &&
    wb_dat_out[8:7] == 2'b00)
    else $error("unimplemented flag bits read nonzero");

  a_irq_above_ipl: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    irq_out.req |-> irq_out.level > $past(cpu_priority_level_in))
    else $error("request not above core level");

  a_irq_present: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    best_ok |=> irq_out.req && irq_out.level == $past(best_lvl))
    else $error("pending request not presented");

  a_wake_sleep: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    wake_out |-> irq_out.req && $past(cpu_sleep_in))
    else $error("wake without request in sleep");

  a_ack_pulse: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    wb_ack_out |=> !wb_ack_out)
    else $error("ack held beyond one cycle");

  a_ack_answer: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("bus request not acknowledged");

  a_fall_edge: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    ctrl2_q[1] && ext_prev_q[1] && !ext_s2_q[1] |=> flags_q[16])
    else $error("falling edge on input one did not set its flag");

  a_wake_present: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    best_ok && cpu_sleep_in |=> wake_out && irq_out.req)
    else $error("sleeping core not woken by request");

  a_alt_follow: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    1'b1 |=> alternate_table_select_out ==
    $past(ctrl2_q[ictl_pkg::ALT_BIT]))
    else $error("table select does not follow control two");

  a_pop_valid: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    shadow_pop_in |=> shadow_pop_valid_out)
    else $error("shadow pop not answered");

  a_ctrl2_unimpl: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    wb_cyc_in && wb_stb_in && !wb_ack_out && idx == ictl_pkg::IDX_CTRL2
    |=> wb_dat_out[13:5] == 9'h000)
    else $error("unimplemented control two bits read nonzero");

  a_ctrl1_unimpl: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    wb_cyc_in && wb_stb_in && !wb_ack_out && idx == ictl_pkg::IDX_CTRL1
    |=> (wb_dat_out[15:0] & ~ictl_pkg::CTRL1_MASK) == 16'h0000)
    else $error("unimplemented control one bits read nonzero");

endmodule : ictl_top

// ### verification/ictl_core_model.sv
`timescale 1ns/1ps
// ==========================================================
// Core side: takes vectors, drives shadow push and pop
module ictl_core_model (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire ictl_pkg::ictl_irq_t irq_in,
  input wire logic take_en_in,
  input wire logic [3:0] base_level_in,
  input wire logic sleep_req_in,
  input wire logic push_req_in,
  input wire logic pop_req_in,
  output logic [3:0] cpu_level_out,
  output logic sleep_out,
  output logic push_out,
  output logic pop_out
);
  logic busy_q;
  logic take;
  assign take = irq_in.req && take_en_in && !busy_q;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      busy_q <= 1'b0;
      cpu_level_out <= 4'h0;
      sleep_out <= 1'b0;
      push_out <= 1'b0;
      pop_out <= 1'b0;
    end else begin
      busy_q <= (busy_q || take) && !pop_req_in;
      cpu_level_out <= take ? irq_in.level :
                       (busy_q ? cpu_level_out : base_level_in);
      sleep_out <= sleep_req_in && !busy_q && !take;
      push_out <= push_req_in || take;
      pop_out <= pop_req_in;
    end
  end
endmodule : ictl_core_model

// ### verification/ictl_tb_top.sv
`timescale 1ns/1ps
module ictl_tb_top;
  logic clk_sys_in, sys_rst_in, cyc, stb, we, ack;
  logic [17:0] adr;
  logic [31:0] wdat, rdat, rd, rng;
  logic [4:0] ext, pol;
  logic [3:0] lvl, base;
  logic sleep, sleep_r, take, push_r, pop_r, push, pop, popv, wake, alt;
  logic [47:0] fexp;
  ictl_pkg::ictl_ctx_t ctx, shd, ctx_a, ctx_b;
  ictl_pkg::ictl_irq_t irq;
  int miscompares, total_checks;
  logic [15:0] idx_q[$], exp_q[$], msk_q[$];

  ictl_top u_ictl_top (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(4'h3), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .ext_request_inputs_in(ext), .periph_req_in(48'h0),
    .cpu_priority_level_in(lvl), .cpu_sleep_in(sleep),
    .temp_disable_active_in(1'b0), .shadow_push_in(push),
    .shadow_pop_in(pop), .core_ctx_in(ctx), .shadow_ctx_out(shd),
    .shadow_pop_valid_out(popv), .irq_out(irq), .wake_out(wake),
    .alternate_table_select_out(alt));
  ictl_core_model u_ictl_core_model (.clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in), .irq_in(irq), .take_en_in(take),
    .base_level_in(base), .sleep_req_in(sleep_r), .push_req_in(push_r),
    .pop_req_in(pop_r), .cpu_level_out(lvl), .sleep_out(sleep),
    .push_out(push), .pop_out(pop));

  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [68:0] seen, input logic [68:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  // Classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [15:0] i,
                    input logic [15:0] d, output logic [31:0] r);
    int n;
    @(posedge clk_sys_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= {16'h0, d};
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      end_of_test();
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // Bounded wait: 0 request, 1 wake, 2 pop valid
  task automatic hold(input int s);
    int n;
    logic v;
    for (n = 0; n < 50; n++) begin
      v = (s == 0) ? irq.req : ((s == 1) ? wake : popv);
      if (v === 1'b1) break;
      @(posedge clk_sys_in);
    end
    if (n == 50) begin
      miscompares++;
      end_of_test();
    end
  endtask : hold

  initial begin
    #200us;
    miscompares++;
    end_of_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    sys_rst_in = 1'b1;
    {cyc, stb, we, adr, wdat, ext, base} = 62'h0;
    {sleep_r, take, push_r, pop_r, ctx, miscompares, total_checks} = 0;
    rng = 32'hf0bc;
    idx_q = '{ictl_pkg::IDX_CTRL1, ictl_pkg::IDX_CTRL2};
    msk_q = '{ictl_pkg::CTRL1_MASK, ictl_pkg::CTRL2_MASK};
    exp_q = '{ictl_pkg::CTRL1_RST, ictl_pkg::CTRL2_RST};
    for (int k = 0; k < 6; k++) begin
      idx_q.push_back(k[0] ? ictl_pkg::EN_IDX[k/2] : ictl_pkg::FLAG_IDX[k/2]);
      msk_q.push_back(ictl_pkg::FLAG_MASK[k/2]);
      exp_q.push_back(16'h0);
    end
    for (int k = 0; k < 11; k++) begin
      idx_q.push_back(ictl_pkg::PRIO_IDX[k]);
      msk_q.push_back(ictl_pkg::PRIO_MASK[k]);
      exp_q.push_back(ictl_pkg::PRIO_RST[k]);
    end
    repeat (3) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    // Nothing pending straight out of reset
    wb(1'b0, ictl_pkg::IDX_PEND, 16'h0, rd);
    chk(rd, 0);
    foreach (idx_q[k]) begin
      wb(1'b0, idx_q[k], 16'h0, rd);
      chk(rd, exp_q[k]);
      wb(1'b1, idx_q[k], 16'hffff, rd);
      exp_q[k] = msk_q[k];
    end
    wb(1'b1, ictl_pkg::IDX_PEND, 16'hffff, rd);
    wb(1'b1, 16'h0090, 16'hffff, rd);
    foreach (idx_q[k]) begin
      wb(1'b0, idx_q[k], 16'h0, rd);
      chk(rd, exp_q[k]);
    end
    // Ties go to source 0, level 7 in every implemented priority field
    wb(1'b0, ictl_pkg::IDX_PEND, 16'h0, rd);
    chk(rd, 32'h0708);
    chk(irq, {1'b1, 4'h7, 6'h08});
    wb(1'b0, 16'h0090, 16'h0, rd);
    chk(rd, 0);
    chk(alt, 1'b1);
    foreach (idx_q[k]) wb(1'b1, idx_q[k], 16'h0, rd);
    chk(alt, 1'b0);
    // Wrong edge first, then the selected edge
    rng = xs(rng);
    pol = rng[4:0];
    fexp = 48'h0;
    for (int e = 0; e < 5; e++) fexp[ictl_pkg::EXT_SRC[e]] = 1'b1;
    wb(1'b1, ictl_pkg::IDX_CTRL2, {11'h0, pol}, rd);
    for (int p = 0; p < 3; p++) begin
      ext <= (p == 1) ? ~pol : pol;
      repeat (6) @(posedge clk_sys_in);
      for (int k = 0; k < 3; k++) begin
        wb(1'b0, ictl_pkg::FLAG_IDX[k], 16'h0, rd);
        chk(rd, p == 1 ? fexp[16*k+:16] : 16'h0);
        if (p == 1) wb(1'b1, ictl_pkg::FLAG_IDX[k], 16'h0, rd);
      end
    end
    // Level 4 against core level 4, then 3
    wb(1'b1, ictl_pkg::EN_IDX[0], 16'h0001, rd);
    wb(1'b1, ictl_pkg::PRIO_IDX[0], 16'h0004, rd);
    base <= 4'h4;
    sleep_r <= 1'b1;
    ext[0] <= ~pol[0];
    repeat (10) @(posedge clk_sys_in);
    chk(irq.req, 1'b0);
    chk(wake, 1'b0);
    base <= 4'h3;
    hold(0);
    chk(irq, {1'b1, 4'h4, ictl_pkg::VEC_BASE});
    wb(1'b0, ictl_pkg::IDX_PEND, 16'h0, rd);
    chk(rd, {20'h0, 4'h4, 2'b0, ictl_pkg::VEC_BASE});
    hold(1);
    chk(wake, 1'b1);
    // Shadow: entry push, overwrite, then pop
    rng = xs(rng);
    ctx_a = {rng[4:0], rng, ~rng};
    ctx <= ctx_a;
    take <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    chk(shd, ctx_a);
    rng = xs(rng);
    ctx_b = {rng[9:5], ~rng, rng};
    take <= 1'b0;
    ctx <= ctx_b;
    push_r <= 1'b1;
    @(posedge clk_sys_in);
    push_r <= 1'b0;
    // Core registers the push, so context stays one edge longer
    @(posedge clk_sys_in);
    ctx <= ~ctx_b;
    repeat (3) @(posedge clk_sys_in);
    chk(shd, ctx_b);
    pop_r <= 1'b1;
    @(posedge clk_sys_in);
    pop_r <= 1'b0;
    hold(2);
    chk(shd, ctx_b);
    end_of_test();
  end
endmodule : ictl_tb_top
